// *** src/rpb_report_builder.sv ***
// Tag-access report packet builder with Avalon-MM register slave and byte stream out
// Operation
// - Phase low seven bits, signed -64..63
// - Phase byte bit seven always zero
// - Older transceiver flag zero gives zero phase
// - Temperature in hardware bytes three:two, signed
// - Frequency kHz in hardware bytes seven:four
// - CRC-16 over signature through padding
// - Packet opens with fixed four-byte signature
// - Every packet exactly sixty-four bytes long
// - Format version field equals one
// - Flag bit zero marks module error
// - Flag bit one marks tag error
// - Flag bits five to two zero
// - Flag bits seven:six hold padding count
// - Report kind field equals six
// - Payload word length never below three
// - Single fragment length is payload bytes/4
// - Hardware data at bytes fourteen to twenty-five
// - Report counter increments per packet
// - Millisecond stamp taken at access time
// - Fragment count field holds packet total
// - Fragment index field holds packet position
// - First fragment tag data from 26, max 36
// - Later fragments tag data from 14, max 48
// - Hardware first fragment, padding last fragment
`include "rpb_defines.svh"

module rpb_report_builder #(
  parameter int          TAG_MAX_BYTES = 128,
  parameter int          MS_CYCLES     = `RPB_MS_PERIOD_NS / `RPB_CLK_PERIOD_NS,
  // Arbitrary value, not tied to any maker
  parameter logic [31:0] SIGNATURE     = 32'h5250_4231
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic      [7:0]  o_pkt_data,
  output logic             o_pkt_valid,
  output logic             o_pkt_sop,
  output logic             o_pkt_eop,
  input  wire logic        i_pkt_ready
);

  localparam int TW = TAG_MAX_BYTES / 4;
  localparam int IW = $clog2(TW);

  if (TAG_MAX_BYTES % 4 != 0 || TAG_MAX_BYTES < 8 || TAG_MAX_BYTES > 188) begin : g_chk_tag
    $error("TAG_MAX_BYTES must be a multiple of 4 in 8..188");
  end
  if (MS_CYCLES < 1) begin : g_chk_ms
    $error("MS_CYCLES must be at least 1");
  end

  rpb_pkg::rpb_state_t state_ff;
  logic        wait_ff;
  logic [31:0] rdata_ff;
  logic        xcvr_ff;
  logic        mod_err_ff;
  logic        tag_err_ff;
  logic [7:0]  ant_ff;
  logic [6:0]  phase_ff;
  logic [15:0] temp_ff;
  logic [31:0] freq_ff;
  logic [7:0]  tag_len_ff;
  logic        done_ff;
  logic [15:0] seq_ff;
  logic [31:0] ms_div_ff;
  logic [31:0] millisecond_stamp_ff;
  logic [31:0] stamp_ff;
  logic [7:0]  frag_ff;
  logic [5:0]  pos_ff;
  logic [15:0] crc_ff;
  logic [31:0] tag_mem_ff [TW];
  logic [7:0]  data_ff;
  logic        valid_ff;
  logic        sop_ff;
  logic        eop_ff;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Byte-wise CRC-16, MSB first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ `RPB_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Bus handshake: every access waits exactly one cycle
  wire acc_go   = (i_avs_read | i_avs_write) & wait_ff;
  wire wr_go    = i_avs_write & ~wait_ff;
  wire busy     = (state_ff == rpb_pkg::RPB_SEND);
  wire wr_ok    = wr_go & ~busy;
  wire [7:0] ad = i_avs_address;

  wire tag_hit   = (ad >= `RPB_REG_TAG_BASE) &&
                   ({1'b0, ad} < 9'({1'b0, `RPB_REG_TAG_BASE}) + 9'(TAG_MAX_BYTES));
  wire [7:0] tag_off = ad - `RPB_REG_TAG_BASE;
  wire [IW-1:0] tag_idx = tag_off[IW+1:2];

  wire wr_ctrl   = wr_go & (ad == `RPB_REG_CTRL);
  wire wr_stat   = wr_go & (ad == `RPB_REG_STATUS);
  wire wr_flags  = wr_ok & (ad == `RPB_REG_FLAGS);
  wire wr_hw0    = wr_ok & (ad == `RPB_REG_HW0);
  wire wr_temp   = wr_ok & (ad == `RPB_REG_TEMP);
  wire wr_freq   = wr_ok & (ad == `RPB_REG_FREQ);
  wire wr_taglen = wr_ok & (ad == `RPB_REG_TAGLEN);
  wire wr_tag    = wr_ok & tag_hit;

  wire [31:0] m_ctrl  = be_merge({30'h0, xcvr_ff, 1'b0}, i_avs_writedata, i_avs_byteenable);
  wire [31:0] m_flags = be_merge({30'h0, tag_err_ff, mod_err_ff}, i_avs_writedata,
                                 i_avs_byteenable);
  wire [31:0] m_hw0   = be_merge({17'h0, phase_ff, ant_ff}, i_avs_writedata, i_avs_byteenable);
  wire [31:0] m_temp  = be_merge({16'h0, temp_ff}, i_avs_writedata, i_avs_byteenable);
  wire [31:0] m_freq  = be_merge(freq_ff, i_avs_writedata, i_avs_byteenable);
  wire [31:0] m_len   = be_merge({24'h0, tag_len_ff}, i_avs_writedata, i_avs_byteenable);
  wire [31:0] m_tag   = be_merge(tag_mem_ff[tag_idx], i_avs_writedata, i_avs_byteenable);
  wire [31:0] m_stat  = be_merge(32'h0, i_avs_writedata, i_avs_byteenable);

  // Over-long lengths clamp so the buffer is never read past its end
  wire [7:0] len_clamped = (m_len[7:0] > 8'(TAG_MAX_BYTES)) ? 8'(TAG_MAX_BYTES) : m_len[7:0];
  wire start_go = wr_ctrl & m_ctrl[`RPB_CTRL_START_BIT] & ~busy;

  // Payload sizes
  wire [1:0]  pad_cnt  = 2'(3'h4 - {1'b0, tag_len_ff[1:0]});
  wire [15:0] pad_len  = 16'(tag_len_ff) + 16'(pad_cnt);
  wire [15:0] rest_len = pad_len - `RPB_TAG_FIRST_MAX;
  wire [15:0] nfrag16  = (pad_len <= `RPB_TAG_FIRST_MAX) ? 16'h0001 :
                         16'h0001 + (rest_len + `RPB_TAG_NEXT_MAX - 16'h0001) /
                         `RPB_TAG_NEXT_MAX;
  wire [7:0]  nfrag    = nfrag16[7:0];
  wire        last_frag = (frag_ff + 8'h01 == nfrag);
  wire [7:0]  flag_byte = {pad_cnt, 4'h0, tag_err_ff, mod_err_ff};
  wire [7:0]  phase_byte = xcvr_ff ? {1'b0, phase_ff} : 8'h00;

  // Words of payload carried by fragment f
  function automatic logic [15:0] inflen(input logic [7:0] f);
    logic [15:0] b;
    logic [15:0] r;
    if (f == 8'h00) begin
      b = `RPB_HW_BYTES + ((pad_len < `RPB_TAG_FIRST_MAX) ? pad_len : `RPB_TAG_FIRST_MAX);
    end else begin
      r = rest_len - 16'(f - 8'h01) * `RPB_TAG_NEXT_MAX;
      b = (r < `RPB_TAG_NEXT_MAX) ? r : `RPB_TAG_NEXT_MAX;
    end
    b = b >> 2;
    return (b < `RPB_MIN_INFLEN) ? `RPB_MIN_INFLEN : b;
  endfunction

  function automatic logic [7:0] hw_byte(input logic [3:0] i);
    logic [7:0] r;
    case (i)
      4'h0:    r = ant_ff;
      4'h1:    r = phase_byte;
      4'h2:    r = temp_ff[7:0];
      4'h3:    r = temp_ff[15:8];
      4'h4:    r = freq_ff[7:0];
      4'h5:    r = freq_ff[15:8];
      4'h6:    r = freq_ff[23:16];
      4'h7:    r = freq_ff[31:24];
      4'h8:    r = stamp_ff[7:0];
      4'h9:    r = stamp_ff[15:8];
      4'hA:    r = stamp_ff[23:16];
      4'hB:    r = stamp_ff[31:24];
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // Byte at offset p of fragment f; checksum bytes are patched in later
  function automatic logic [7:0] build_byte(input logic [7:0] f, input logic [5:0] p);
    logic [15:0] t;
    logic [15:0] il;
    logic [31:0] w;
    logic [7:0]  r;
    il = inflen(f);
    t  = (f == 8'h00) ? 16'(p) - 16'(`RPB_POS_TAG_FIRST) :
         `RPB_TAG_FIRST_MAX + 16'(f - 8'h01) * `RPB_TAG_NEXT_MAX +
         16'(p) - 16'(`RPB_POS_PAY_START);
    w  = tag_mem_ff[t[IW+1:2]];
    r  = 8'h00;
    case (p)
      6'h00, 6'h01, 6'h02, 6'h03: r = SIGNATURE[8*(3 - int'(p)) +: 8];
      6'h04:   r = nfrag;
      6'h05:   r = f + 8'h01;
      6'h06:   r = `RPB_VERSION;
      6'h07:   r = flag_byte;
      6'h08:   r = 8'(`RPB_RPT_TYPE >> 8);
      6'h09:   r = 8'(`RPB_RPT_TYPE & 16'h00FF);
      6'h0A:   r = il[15:8];
      6'h0B:   r = il[7:0];
      6'h0C:   r = seq_ff[15:8];
      6'h0D:   r = seq_ff[7:0];
      default: begin
        if (f == 8'h00 && p <= `RPB_POS_HW_END) begin
          r = hw_byte(4'(p - `RPB_POS_PAY_START));
        end else if (p <= `RPB_POS_PAY_END && t < 16'(tag_len_ff)) begin
          r = w[8*t[1:0] +: 8];
        end
      end
    endcase
    return r;                                                              // padding reads zero
  endfunction

  // Next byte to present
  wire        hs       = valid_ff & i_pkt_ready;
  wire        pkt_end  = hs & (pos_ff == `RPB_POS_LAST);
  wire        frag_adv = pkt_end & ~last_frag;
  wire [7:0]  sel_f    = start_go ? 8'h00 : (frag_adv ? frag_ff + 8'h01 : frag_ff);
  wire [5:0]  sel_p    = (start_go | pkt_end) ? 6'h00 : pos_ff + 6'h01;
  wire [15:0] crc_nxt  = crc_step(crc_ff, data_ff);
  wire        crc_upd  = hs & (pos_ff <= `RPB_POS_PAY_END);
  wire [7:0]  body     = build_byte(sel_f, sel_p);
  wire [7:0]  nxt_data = (sel_p == `RPB_POS_CRC_HI) ? crc_nxt[15:8] :
                         (sel_p == `RPB_POS_LAST)   ? crc_ff[7:0]   : body;
  wire        load     = start_go | (hs & ~(pkt_end & last_frag));

  wire [31:0] rd_mux =
    (ad == `RPB_REG_CTRL)   ? {30'h0, xcvr_ff, 1'b0} :
    (ad == `RPB_REG_STATUS) ? {seq_ff, nfrag, 6'h0, done_ff, busy} :
    (ad == `RPB_REG_FLAGS)  ? {30'h0, tag_err_ff, mod_err_ff} :
    (ad == `RPB_REG_HW0)    ? {17'h0, phase_ff, ant_ff} :
    (ad == `RPB_REG_TEMP)   ? {16'h0, temp_ff} :
    (ad == `RPB_REG_FREQ)   ? freq_ff :
    (ad == `RPB_REG_TAGLEN) ? {24'h0, tag_len_ff} :
    (ad == `RPB_REG_MS_NOW) ? millisecond_stamp_ff :
    (ad == `RPB_REG_STAMP)  ? stamp_ff :
    tag_hit                 ? tag_mem_ff[tag_idx] : `RPB_RST_WORD;

  wire ms_tick = (ms_div_ff == 32'(MS_CYCLES - 1));

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_ff  <= 1'b1;
      rdata_ff <= `RPB_RST_WORD;
    end else begin
      wait_ff <= ~acc_go;
      if (acc_go & i_avs_read) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      xcvr_ff    <= 1'b0;
      mod_err_ff <= 1'b0;
      tag_err_ff <= 1'b0;
      ant_ff     <= `RPB_RST_BYTE;
      phase_ff   <= 7'h00;
      temp_ff    <= 16'h0000;
      freq_ff    <= `RPB_RST_WORD;
      tag_len_ff <= `RPB_RST_BYTE;
    end else begin
      if (wr_ctrl & ~busy) begin
        xcvr_ff <= m_ctrl[`RPB_CTRL_XCVR_BIT];
      end
      if (wr_flags) begin
        mod_err_ff <= m_flags[`RPB_FLAG_MOD_BIT];
        tag_err_ff <= m_flags[`RPB_FLAG_TAG_BIT];
      end
      if (wr_hw0) begin
        ant_ff   <= m_hw0[7:0];
        phase_ff <= m_hw0[14:8];
      end
      if (wr_temp) begin
        temp_ff <= m_temp[15:0];
      end
      if (wr_freq) begin
        freq_ff <= m_freq;
      end
      if (wr_taglen) begin
        tag_len_ff <= len_clamped;
      end
    end
  end

  // Tag buffer has no reset; length gates every packet read of it, bus reads return it ungated
  always_ff @(posedge i_ref_clk) begin
    if (wr_tag) begin
      tag_mem_ff[tag_idx] <= m_tag;
    end
  end

  // Free-running millisecond count
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ms_div_ff            <= `RPB_RST_WORD;
      millisecond_stamp_ff <= `RPB_RST_WORD;
      stamp_ff             <= `RPB_RST_WORD;
    end else begin
      ms_div_ff <= ms_tick ? `RPB_RST_WORD : ms_div_ff + 32'h1;
      if (ms_tick) begin
        millisecond_stamp_ff <= millisecond_stamp_ff + 32'h1;
      end
      if (start_go) begin
        stamp_ff <= millisecond_stamp_ff;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= rpb_pkg::RPB_IDLE;
      frag_ff  <= `RPB_RST_BYTE;
      pos_ff   <= 6'h00;
      crc_ff   <= `RPB_CRC_INIT;
      seq_ff   <= 16'h0000;
      done_ff  <= 1'b0;
      data_ff  <= `RPB_RST_BYTE;
      valid_ff <= 1'b0;
      sop_ff   <= 1'b0;
      eop_ff   <= 1'b0;
    end else begin
      if (pkt_end) begin
        seq_ff <= seq_ff + 16'h0001;
      end
      // Set beats a same-cycle clear
      if (pkt_end & last_frag) begin
        done_ff <= 1'b1;
      end else if (wr_stat & m_stat[`RPB_STAT_DONE_BIT]) begin
        done_ff <= 1'b0;
      end
      if (crc_upd) begin
        crc_ff <= crc_nxt;
      end else if (start_go | pkt_end) begin
        crc_ff <= `RPB_CRC_INIT;
      end
      if (load) begin
        data_ff <= nxt_data;
        frag_ff <= sel_f;
        pos_ff  <= sel_p;
        sop_ff  <= (sel_p == 6'h00);
        eop_ff  <= (sel_p == `RPB_POS_LAST);
      end
      case (state_ff)
        rpb_pkg::RPB_IDLE: begin
          if (start_go) begin
            state_ff <= rpb_pkg::RPB_SEND;
            valid_ff <= 1'b1;
          end
        end
        rpb_pkg::RPB_SEND: begin
          if (pkt_end & last_frag) begin
            state_ff <= rpb_pkg::RPB_IDLE;
            valid_ff <= 1'b0;
          end
        end
        default: begin
          state_ff <= rpb_pkg::RPB_IDLE;
          valid_ff <= 1'b0;
        end
      endcase
    end
  end

  assign o_avs_readdata    = rdata_ff;
  assign o_avs_waitrequest = wait_ff;
  assign o_pkt_data        = data_ff;
  assign o_pkt_valid       = valid_ff;
  assign o_pkt_sop         = sop_ff;
  assign o_pkt_eop         = eop_ff;

endmodule // rpb_report_builder

// *** src/rpb_defines.svh ***
// Offsets, field positions, reset values and timing periods of the report builder
`ifndef RPB_DEFINES_SVH
`define RPB_DEFINES_SVH

`define RPB_REG_CTRL        8'h00
`define RPB_REG_STATUS      8'h04
`define RPB_REG_FLAGS       8'h08
`define RPB_REG_HW0         8'h0C
`define RPB_REG_TEMP        8'h10
`define RPB_REG_FREQ        8'h14
`define RPB_REG_TAGLEN      8'h18
`define RPB_REG_MS_NOW      8'h1C
`define RPB_REG_STAMP       8'h20
`define RPB_REG_TAG_BASE    8'h40

`define RPB_CTRL_START_BIT  0
`define RPB_CTRL_XCVR_BIT   1
`define RPB_STAT_BUSY_BIT   0
`define RPB_STAT_DONE_BIT   1
`define RPB_FLAG_MOD_BIT    0
`define RPB_FLAG_TAG_BIT    1

`define RPB_PKT_LEN         7'h40
`define RPB_POS_LAST        6'h3F
`define RPB_POS_CRC_HI      6'h3E
`define RPB_POS_PAY_END     6'h3D
`define RPB_POS_PAY_START   6'h0E
`define RPB_POS_HW_END      6'h19
`define RPB_POS_TAG_FIRST   6'h1A
`define RPB_HW_BYTES        16'h000C
`define RPB_TAG_FIRST_MAX   16'h0024
`define RPB_TAG_NEXT_MAX    16'h0030
`define RPB_MIN_INFLEN      16'h0003

`define RPB_VERSION         8'h01
`define RPB_RPT_TYPE        16'h0006
`define RPB_CRC_INIT        16'hFFFF
`define RPB_CRC_POLY        16'h1021
`define RPB_RST_BYTE        8'h00
`define RPB_RST_WORD        32'h0000_0000

`define RPB_MS_PERIOD_NS    1000000
`define RPB_CLK_PERIOD_NS   5

`endif

// *** src/rpb_pkg.sv ***
// Types shared by the report builder
package rpb_pkg;
  typedef enum logic [0:0] {
    RPB_IDLE,
    RPB_SEND
  } rpb_state_t;
  typedef logic [7:0] rpb_byte_t;
endpackage

// *** bench/rpb_report_builder_asserts.sv ***
// Port-level checker of the report builder
module rpb_report_builder_asserts #(
  parameter logic [31:0] SIGNATURE = 32'h5250_4231
) (
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic [7:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic [7:0]  o_pkt_data,
  input wire logic        o_pkt_valid,
  input wire logic        o_pkt_sop,
  input wire logic        o_pkt_eop,
  input wire logic        i_pkt_ready
);
  logic [5:0] idx_ff;
  logic [7:0] fidx_ff;
  wire        take = o_pkt_valid && i_pkt_ready;
  wire [7:0]  sig_byte = SIGNATURE[8 * (3 - idx_ff[1:0]) +: 8];
  // Offset follows takes; every packet is exactly 64 bytes long
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      idx_ff  <= 6'h00;
      fidx_ff <= 8'h00;
    end else begin
      if (take) begin
        idx_ff <= idx_ff + 6'h01;
      end
      // Fragment index byte tells where the hardware data lives
      if (take && idx_ff == 6'h05) begin
        fidx_ff <= o_pkt_data;
      end
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  sequence s_ack;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  property p_ack_bound;
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> s_ack;
  endproperty
  property p_ack_cause;
    $fell(o_avs_waitrequest) |-> $past(i_avs_read || i_avs_write);
  endproperty
  property p_sig;
    o_pkt_valid && idx_ff < 6'h04 |-> o_pkt_data == sig_byte;
  endproperty
  property p_sop;
    o_pkt_valid |-> o_pkt_sop == (idx_ff == 6'h00);
  endproperty
  property p_eop;
    o_pkt_valid |-> o_pkt_eop == (idx_ff == 6'h3F);
  endproperty
  property p_hold;
    o_pkt_valid && !i_pkt_ready |=> o_pkt_valid && $stable(o_pkt_data) && $stable(o_pkt_sop);
  endproperty
  property p_version;
    o_pkt_valid && idx_ff == 6'h06 |-> o_pkt_data == 8'h01;
  endproperty
  property p_flag_rsvd;
    o_pkt_valid && idx_ff == 6'h07 |-> o_pkt_data[5:2] == 4'h0;
  endproperty
  property p_kind;
    o_pkt_valid && (idx_ff == 6'h08 || idx_ff == 6'h09)
      |-> o_pkt_data == ((idx_ff == 6'h09) ? 8'h06 : 8'h00);
  endproperty
  property p_phase_msb;
    o_pkt_valid && idx_ff == 6'h0F && fidx_ff == 8'h01 |-> !o_pkt_data[7];
  endproperty
  a_ack_bound: assert property (p_ack_bound) else $error("no single-cycle acknowledge");
  a_ack_cause: assert property (p_ack_cause) else $error("acknowledge without request");
  a_sig: assert property (p_sig) else $error("signature byte wrong");
  a_sop: assert property (p_sop) else $error("start marker misplaced");
  a_eop: assert property (p_eop) else $error("end marker misplaced");
  a_hold: assert property (p_hold) else $error("byte changed before taken");
  a_version: assert property (p_version) else $error("version wrong");
  a_flag_rsvd: assert property (p_flag_rsvd) else $error("flag spare bits set");
  a_kind: assert property (p_kind) else $error("report kind wrong");
  a_phase_msb: assert property (p_phase_msb) else $error("phase top bit set");
endmodule // rpb_report_builder_asserts

// *** bench/rpb_host_sink.sv ***
// Host-side byte sink with optional random stalls
module rpb_host_sink (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_stall_en,
  input  wire logic [7:0]  i_data,
  input  wire logic        i_valid,
  output logic             o_ready,
  output logic      [15:0] o_count
);
  logic [7:0]  mem [256];
  logic [15:0] lfsr_ff;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      lfsr_ff <= 16'hACE1;
      o_ready <= 1'b0;
      o_count <= 16'h0000;
    end else begin
      lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
      o_ready <= !i_stall_en || lfsr_ff[0];
      if (i_valid && o_ready) begin
        mem[o_count[7:0]] <= i_data;
        o_count <= o_count + 16'h0001;
      end
    end
  end
endmodule // rpb_host_sink

// *** bench/rpb_report_builder_test.sv ***
// Self-checking bench of the report builder
`include "rpb_defines.svh"
module rpb_report_builder_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] SIG = 32'h1A2B_3C4D; // Arbitrary value
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic        stall = 1'b0;
  logic [31:0] rdat;
  logic [31:0] rs = 32'hD922_34D1;
  logic        wq, pv, ps, pe, prdy;
  logic [7:0]  pd;
  logic [15:0] cnt;
  logic [15:0] seq = 16'h0000;
  int          miscompares, samples_checked;
  int          lens [8] = '{0, 3, 36, 37, 84, 85, 128, 0};
  always #2.5 clk = !clk;
  rpb_report_builder #(.MS_CYCLES(10), .SIGNATURE(SIG)) u_dut (
    .i_ref_clk(clk), .i_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wq), .o_pkt_data(pd),
    .o_pkt_valid(pv), .o_pkt_sop(ps), .o_pkt_eop(pe), .i_pkt_ready(prdy));
  rpb_host_sink u_host (.i_clk(clk), .i_rst(rst), .i_stall_en(stall), .i_data(pd),
    .i_valid(pv), .o_ready(prdy), .o_count(cnt));
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic logic [15:0] crc(input logic [7:0] b [64]);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < 62; i++) begin
      c = c ^ {b[i], 8'h00};
      for (int j = 0; j < 8; j++) c = {c[14:0], 1'b0} ^ (c[15] ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (e !== g) begin
      miscompares++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 50);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      chk(0, 1);
      end_of_test();
    end
  endtask
  task automatic run(input int len);
    logic [31:0] hw, tp, fq, fl, ms, q, x;
    logic [7:0]  tg [128];
    logic [7:0]  e [64];
    logic [7:0]  g [64];
    logic [15:0] base;
    logic        xc;
    int          pl, nf, t0, inb, mx, pb, pos, n;
    hw = xs();
    tp = xs();
    fq = xs();
    fl = xs() & 32'h3;
    xc = rs[7];
    bus(1, `RPB_REG_FLAGS, fl, q);
    bus(1, `RPB_REG_HW0, hw, q);
    bus(1, `RPB_REG_TEMP, tp, q);
    bus(1, `RPB_REG_FREQ, fq, q);
    bus(1, `RPB_REG_TAGLEN, len, q);
    for (int k = 0; k < (len + 3) / 4; k++) begin
      x = xs();
      bus(1, 8'(`RPB_REG_TAG_BASE + 4 * k), x, q);
      for (int j = 0; j < 4; j++) tg[4 * k + j] = x[8 * j +: 8];
    end
    bus(0, `RPB_REG_MS_NOW, 32'h0, ms);
    base = cnt;
    bus(1, `RPB_REG_CTRL, {30'h0, xc, 1'b1}, q);
    bus(1, `RPB_REG_CTRL, 32'h3, q);
    bus(0, 8'h30, 32'h0, q);
    chk(0, q);
    pl = (len + 3) & ~3;
    nf = (pl <= 36) ? 1 : 1 + (pl - 36 + 47) / 48;
    n = 0;
    while (cnt !== 16'(base + 64 * nf) && n < 9000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 9000) begin
      chk(0, 1);
      end_of_test();
    end
    repeat (4) @(posedge clk);
    chk(16'(base + 64 * nf), cnt);
    chk(0, pv);
    for (int f = 1; f <= nf; f++) begin
      for (int i = 0; i < 64; i++) begin
        e[i] = 8'h00;
        g[i] = u_host.mem[8'(base + 64 * (f - 1) + i)];
      end
      {e[0], e[1], e[2], e[3]} = SIG;
      e[4] = 8'(nf);
      e[5] = 8'(f);
      e[6] = 8'h01;
      e[7] = {2'(pl - len), 4'h0, fl[1:0]};
      e[9] = 8'h06;
      t0 = (f == 1) ? 0 : 36 + 48 * (f - 2);
      mx = (f == 1) ? 36 : 48;
      inb = (pl - t0 > mx) ? mx : pl - t0;
      pb = inb + ((f == 1) ? 12 : 0);
      {e[10], e[11]} = 16'((pb / 4 < 3) ? 3 : pb / 4);
      {e[12], e[13]} = seq;
      seq++;
      pos = (f == 1) ? 26 : 14;
      if (f == 1) begin
        e[14] = hw[7:0];
        e[15] = xc ? {1'b0, hw[14:8]} : 8'h00;
        {e[17], e[16]} = tp[15:0];
        {e[21], e[20], e[19], e[18]} = fq;
        x = {g[25], g[24], g[23], g[22]};
        chk(1, x >= ms && x <= ms + 1);
        {e[25], e[24], e[23], e[22]} = x;
      end
      for (int i = 0; i < inb; i++) e[pos + i] = (t0 + i < len) ? tg[t0 + i] : 8'h00;
      {e[62], e[63]} = crc(e);
      for (int i = 0; i < 64; i++) chk(e[i], g[i]);
      // Byte loop above also
    end
    bus(0, `RPB_REG_STATUS, 32'h0, q);
    chk({seq, 8'(nf), 8'h02}, q);
    bus(1, `RPB_REG_STATUS, 32'h2, q);
    bus(0, `RPB_REG_STATUS, 32'h0, q);
    chk({seq, 8'(nf), 8'h00}, q);
    // Second start came while busy, so the transceiver bit must be unchanged
    bus(0, `RPB_REG_CTRL, 32'h0, q);
    chk({30'h0, xc, 1'b0}, q);
    bus(0, `RPB_REG_STAMP, 32'h0, q);
    chk(x, q);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    lens[7] = int'(xs() % 129);
    for (int i = 0; i < 8; i++) begin
      stall <= i[0];
      run(lens[i]);
    end
    end_of_test();
  end
endmodule // rpb_report_builder_test
bind rpb_report_builder rpb_report_builder_asserts #(.SIGNATURE(SIGNATURE)) u_chk (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_pkt_data(o_pkt_data),
  .o_pkt_valid(o_pkt_valid), .o_pkt_sop(o_pkt_sop), .o_pkt_eop(o_pkt_eop),
  .i_pkt_ready(i_pkt_ready));
